//--- verilog/mio_pkg.sv
// Constants and carrier types for the multiplexed I/O port set.
// Assumes one pclk domain and an APB master with 32-bit data.
// Overview of operation
// R1: First three ports: per-bit direction, reset input
// R2: Fourth port: per-bit direction, reset input
// R3: Fifth port: six fixed inputs, two outputs
// R4: Three external requests fire on falling edges
// R5: First port top pins feed sync, gated
// R6: Serial block drives clock and output pins
// R7: Fourth port pins feed serial, counters, receiver
// R8: Analog pins selectable, digital read at reset
// R9: Fifth port outputs select data or alternate
// R10: Sixth port open drain, PWM or I2C
// R11: Display outputs float until polarity written
// R12: Reset pin low-active, driven during power-on
// R13: Board ties test mode pin low
// R14: Port read: pins for inputs, latch otherwise
package mio_pkg;

    // =========================================================
    // Register byte addresses and word indices
    localparam logic [7:0] A_P1_DATA = 8'h00;
    localparam logic [7:0] A_P1_DIR  = 8'h04;
    localparam logic [7:0] A_P2_DATA = 8'h08;
    localparam logic [7:0] A_P2_DIR  = 8'h0c;
    localparam logic [7:0] A_P3_DATA = 8'h10;
    localparam logic [7:0] A_P3_DIR  = 8'h14;
    localparam logic [7:0] A_P4_DATA = 8'h18;
    localparam logic [7:0] A_P4_DIR  = 8'h1c;
    localparam logic [7:0] A_P5_DATA = 8'h20;
    localparam logic [7:0] A_P5_FSEL = 8'h24;
    localparam logic [7:0] A_P6_DATA = 8'h28;
    localparam logic [7:0] A_P6_PWM  = 8'h2c;
    localparam logic [7:0] A_P6_I2C  = 8'h30;
    localparam logic [7:0] A_MISC    = 8'h34;
    localparam logic [7:0] A_POL     = 8'h38;
    localparam logic [3:0] IDX_P5_DATA = 4'h8;
    localparam logic [3:0] IDX_P5_FSEL = 4'h9;
    localparam logic [3:0] IDX_P6_DATA = 4'ha;
    localparam logic [3:0] IDX_P6_PWM  = 4'hb;
    localparam logic [3:0] IDX_P6_I2C  = 4'hc;
    localparam logic [3:0] IDX_MISC    = 4'hd;
    localparam logic [3:0] IDX_POL     = 4'he;
    localparam logic [3:0] IDX_NONE    = 4'hf;

    // =========================================================
    // Field positions
    localparam int MISC_SYNC = 0;
    localparam int MISC_SCK  = 1;
    localparam int MISC_SO   = 2;
    localparam int P4_SCK    = 1;
    localparam int P4_SO     = 2;

    // =========================================================
    // Reset values
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_P5_DATA = 8'hc0;
    localparam logic [7:0] RST_P5_FSEL = 8'hc0;
    localparam logic [7:0] P5_OE       = 8'hc0;
    localparam logic [7:0] RST_P6_DATA = 8'hff;

    // =========================================================
    // Carrier types
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } mio_pin_drv_t;

endpackage : mio_pkg

//--- verilog/mio_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes pins idle high; level changes once stages two and three agree.
`timescale 1ns/1ps
module mio_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);
    import mio_pkg::*;

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;
    logic [W-1:0] lvl_nxt;

    // =========================================================
    // Agreement filter
    assign lvl_nxt = (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
    assign level   = lvl_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r  <= '1;
            s2_r  <= '1;
            s3_r  <= '1;
            lvl_r <= '1;
        end else begin
            s1_r  <= pin_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

endmodule : mio_pin_sync

//--- verilog/mio_port_set.sv
// Multiplexed I/O port set: six ports, alternate functions, APB registers.
// Assumes peripheral blocks on pclk; pins are asynchronous to pclk.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module mio_port_set #(
    parameter bit POR_OPTION = 1'b1
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [7:0]            port_first_in,
    input  wire logic [7:0]            port_second_in,
    input  wire logic [7:0]            port_third_in,
    input  wire logic [7:0]            port_fourth_in,
    input  wire logic [5:0]            port_fifth_in,
    input  wire logic [7:0]            port_sixth_in,
    output mio_pkg::mio_pin_drv_t      port_first_drv,
    output mio_pkg::mio_pin_drv_t      port_second_drv,
    output mio_pkg::mio_pin_drv_t      port_third_drv,
    output mio_pkg::mio_pin_drv_t      port_fourth_drv,
    output mio_pkg::mio_pin_drv_t      port_fifth_drv,
    output mio_pkg::mio_pin_drv_t      port_sixth_drv,
    output logic                       screen_overlay_vsync,
    output logic                       screen_overlay_hsync,
    output logic                       ext_irq_a,
    output logic                       ext_irq_b,
    output logic                       ext_irq_c,
    input  wire logic                  ser_sck_o,
    input  wire logic                  ser_sck_oe,
    input  wire logic                  ser_so_o,
    input  wire logic                  ser_so_oe,
    output logic                       ser_sck_in,
    output logic                       ser_si_in,
    output logic                       line_count_in_a,
    output logic                       line_count_in_b,
    output logic                       remote_rx_in,
    output logic                       event_count_in,
    output logic      [3:0]            analog_in_sel,
    input  wire logic                  wide_pwm_in,
    input  wire logic                  timer_square_out,
    input  wire logic [7:0]            narrow_pwm_in,
    input  wire logic [3:0]            i2c_line_drv,
    output logic      [3:0]            i2c_line_in,
    input  wire logic [5:0]            disp_in,
    output mio_pkg::mio_pin_drv_t      disp_drv,
    input  wire logic                  rst_pin_in,
    input  wire logic                  por_active,
    output logic                       rst_pin_o,
    output logic                       rst_pin_oe,
    output logic                       sys_reset_n
);
    import mio_pkg::*;

    localparam int NW = 47;

    // =========================================================
    // Declarations
    logic [NW-1:0]  pin_raw;
    logic [NW-1:0]  lvl;
    logic [7:0]     lvp [4];
    logic [7:0]     lv5;
    logic [7:0]     lv6;
    logic [7:0]     data_r [4];
    logic [7:0]     dir_r [4];
    logic [7:0]     p5_data_r;
    logic [7:0]     p5_fsel_r;
    logic [7:0]     p6_data_r;
    logic [7:0]     p6_pwm_r;
    logic [3:0]     p6_i2c_r;
    logic [2:0]     misc_r;
    logic [5:0]     pol_r;
    logic           disp_act_r;
    logic [7:0]     rd_word [16];
    logic [3:0]     idx;
    logic           setup;
    logic           addr_ok;
    logic           wr_hit;
    logic [7:0]     p6_lvl;
    mio_pin_drv_t   pd_nxt [6];
    mio_pin_drv_t   pd_r [6];
    logic [2:0]     irq_d_r;
    logic [2:0]     irq_r;
    logic [5:0]     alt_r;
    logic [3:0]     i2c_in_r;
    logic           vsync_r;
    logic           hsync_r;
    logic           rst_oe_r;
    logic           sysrst_r;
    logic [31:0]    prdata_r;
    logic           pready_r;
    logic           pslverr_r;

    function automatic logic [7:0] mio_mix(input logic [7:0] d, input logic [7:0] dir, input logic [7:0] pin);
        return (d & dir) | (pin & ~dir);
    endfunction : mio_mix

    // =========================================================
    // Pin synchronisers
    assign pin_raw = {rst_pin_in, port_sixth_in, port_fifth_in, port_fourth_in,
                      port_third_in, port_second_in, port_first_in};

    mio_pin_sync #(.W(NW)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (pin_raw),
        .level   (lvl)
    );

    assign lv5 = {2'b00, lvl[37:32]};
    assign lv6 = lvl[45:38];

    // =========================================================
    // APB decode and read selection
    assign setup   = psel & ~penable;
    assign idx     = paddr[5:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) && (idx != IDX_NONE);
    assign wr_hit  = psel & penable & pready_r & pwrite & addr_ok;

    genvar g;
    for (g = 0; g < 4; g++) begin : g_port
        assign lvp[g] = lvl[8*g +: 8];
        // R14: Mixed read-back
        assign rd_word[2*g]     = mio_mix(data_r[g], dir_r[g], lvp[g]);
        assign rd_word[2*g + 1] = dir_r[g];
    end

    // R8: Analog pins read zero
    assign rd_word[IDX_P5_DATA] = {p5_data_r[7:6], lv5[5:2] & ~p5_fsel_r[5:2], lv5[1:0]};
    assign rd_word[IDX_P5_FSEL] = p5_fsel_r;
    assign rd_word[IDX_P6_DATA] = p6_data_r;
    assign rd_word[IDX_P6_PWM]  = p6_pwm_r;
    assign rd_word[IDX_P6_I2C]  = {4'h0, p6_i2c_r};
    assign rd_word[IDX_MISC]    = {5'h00, misc_r};
    assign rd_word[IDX_POL]     = {2'b00, pol_r};
    assign rd_word[IDX_NONE]    = RST_ZERO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~addr_ok;
            if (setup) begin
                prdata_r <= {24'h00_0000, rd_word[idx]};
            end
        end
    end

    // =========================================================
    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                data_r[i] <= RST_ZERO;
                // R1: Direction clears at reset
                dir_r[i]  <= RST_ZERO;
            end
            p5_data_r  <= RST_P5_DATA;
            p5_fsel_r  <= RST_P5_FSEL;
            p6_data_r  <= RST_P6_DATA;
            p6_pwm_r   <= RST_ZERO;
            p6_i2c_r   <= 4'h0;
            misc_r     <= 3'h0;
            pol_r      <= 6'h00;
            disp_act_r <= 1'b0;
        end else if (wr_hit) begin
            case (idx)
                IDX_P5_DATA: p5_data_r <= pwdata[7:0] & P5_OE;
                IDX_P5_FSEL: p5_fsel_r <= pwdata[7:0] & 8'hfc;
                IDX_P6_DATA: p6_data_r <= pwdata[7:0];
                IDX_P6_PWM:  p6_pwm_r  <= pwdata[7:0];
                IDX_P6_I2C:  p6_i2c_r  <= pwdata[3:0];
                IDX_MISC:    misc_r    <= pwdata[2:0];
                IDX_POL: begin
                    pol_r      <= pwdata[5:0];
                    // R11: Polarity write activates outputs
                    disp_act_r <= 1'b1;
                end
                default: begin
                    if (idx[0]) begin
                        dir_r[idx[2:1]]  <= pwdata[7:0];
                    end else begin
                        data_r[idx[2:1]] <= pwdata[7:0];
                    end
                end
            endcase
        end
    end

    // =========================================================
    // Pin drive selection
    // R1: Plain ports follow direction
    assign pd_nxt[0] = '{o: data_r[0], oe: dir_r[0]};
    assign pd_nxt[1] = '{o: data_r[1], oe: dir_r[1]};
    assign pd_nxt[2] = '{o: data_r[2], oe: dir_r[2]};
    // R2: Fourth port direction, R6: serial overrides
    assign pd_nxt[3] = '{o: {data_r[3][7:3],
                             misc_r[MISC_SO]  ? ser_so_o   : data_r[3][P4_SO],
                             misc_r[MISC_SCK] ? ser_sck_o  : data_r[3][P4_SCK],
                             data_r[3][0]},
                         oe: {dir_r[3][7:3],
                              misc_r[MISC_SO]  ? ser_so_oe  : dir_r[3][P4_SO],
                              misc_r[MISC_SCK] ? ser_sck_oe : dir_r[3][P4_SCK],
                              dir_r[3][0]}};
    // R3: Fixed directions, R9: data or alternate
    assign pd_nxt[4] = '{o: {p5_fsel_r[7] ? p5_data_r[7] : timer_square_out,
                             p5_fsel_r[6] ? p5_data_r[6] : wide_pwm_in, 6'h00},
                         oe: P5_OE};
    // R10: Open-drain sixth port
    for (g = 0; g < 8; g++) begin : g_p6
        if (g >= 4) begin : g_i2c
            assign p6_lvl[g] = p6_i2c_r[g-4] ? i2c_line_drv[g-4]
                             : (p6_pwm_r[g] ? narrow_pwm_in[g] : p6_data_r[g]);
        end else begin : g_pwm
            assign p6_lvl[g] = p6_pwm_r[g] ? narrow_pwm_in[g] : p6_data_r[g];
        end
    end
    assign pd_nxt[5] = '{o: RST_ZERO, oe: ~p6_lvl};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 6; i++) begin
                pd_r[i] <= '{o: RST_ZERO, oe: RST_ZERO};
            end
            pd_r[4]  <= '{o: RST_P5_DATA, oe: P5_OE};
            disp_drv <= '{o: RST_ZERO, oe: RST_ZERO};
            rst_oe_r <= 1'b0;
        end else begin
            pd_r     <= pd_nxt;
            // R11: Display driven once active
            disp_drv <= '{o: {2'b00, disp_in ^ pol_r}, oe: {2'b00, {6{disp_act_r}}}};
            // R12: Drive reset pin during power-on
            rst_oe_r <= POR_OPTION & por_active;
        end
    end

    // =========================================================
    // Alternate inputs and edge requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_d_r  <= 3'h7;
            irq_r    <= 3'h0;
            alt_r    <= 6'h3f;
            i2c_in_r <= 4'hf;
            vsync_r  <= 1'b1;
            hsync_r  <= 1'b1;
            sysrst_r <= 1'b1;
        end else begin
            // R4: Falling-edge requests
            irq_d_r  <= {lvp[3][0], lv5[1], lv5[0]};
            irq_r    <= irq_d_r & ~{lvp[3][0], lv5[1], lv5[0]};
            // R7: Route fourth port levels
            alt_r    <= {lvp[3][7:3], lvp[3][P4_SCK]};
            i2c_in_r <= lv6[7:4];
            // R5: Sync gated by selector
            vsync_r  <= misc_r[MISC_SYNC] ? lvp[0][6] : 1'b1;
            hsync_r  <= misc_r[MISC_SYNC] ? lvp[0][7] : 1'b1;
            sysrst_r <= lvl[46];
        end
    end

    // =========================================================
    // Outputs
    assign port_first_drv       = pd_r[0];
    assign port_second_drv      = pd_r[1];
    assign port_third_drv       = pd_r[2];
    assign port_fourth_drv      = pd_r[3];
    assign port_fifth_drv       = pd_r[4];
    assign port_sixth_drv       = pd_r[5];
    assign ext_irq_a            = irq_r[0];
    assign ext_irq_b            = irq_r[1];
    assign ext_irq_c            = irq_r[2];
    assign ser_sck_in           = alt_r[0];
    assign ser_si_in            = alt_r[1];
    assign line_count_in_a      = alt_r[2];
    assign line_count_in_b      = alt_r[3];
    assign remote_rx_in         = alt_r[4];
    assign event_count_in       = alt_r[5];
    assign analog_in_sel        = p5_fsel_r[5:2];
    assign i2c_line_in          = i2c_in_r;
    assign screen_overlay_vsync = vsync_r;
    assign screen_overlay_hsync = hsync_r;
    assign rst_pin_o            = 1'b0;
    assign rst_pin_oe           = rst_oe_r;
    assign sys_reset_n          = sysrst_r;
    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = pslverr_r;

    // =========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_p1;
        setup && !pwrite && paddr == A_P1_DATA;
    endsequence

    sequence s_fall_a;
        $fell(lv5[0]);
    endsequence

    a_dir_to_oe: assert property (1'b1 |=> pd_r[0].oe == $past(dir_r[0])) // R1
        else $error("first port enable does not follow direction");
    a_p4_dir_oe: assert property (!misc_r[MISC_SCK] |=> pd_r[3].oe[1] == $past(dir_r[3][1])) // R2
        else $error("fourth port enable does not follow direction");
    a_p5_fixed_dir: assert property (pd_r[4].oe == P5_OE) // R3
        else $error("fifth port direction not fixed");
    a_irq_edge_pulse: assert property (s_fall_a |=> ext_irq_a ##1 !ext_irq_a) // R4
        else $error("falling edge request not one pulse");
    a_sync_gate: assert property (!misc_r[MISC_SYNC] |=> vsync_r && hsync_r) // R5
        else $error("sync passed while not selected");
    a_sck_serial_oe: assert property (misc_r[MISC_SCK] |=> pd_r[3].oe[1] == $past(ser_sck_oe)) // R6
        else $error("serial clock enable not passed");
    a_event_route: assert property (1'b1 |=> event_count_in == $past(lvl[31])) // R7
        else $error("event input not routed");
    a_analog_mask: assert property (setup && paddr == A_P5_DATA && p5_fsel_r[2] |=> prdata[2] == 1'b0) // R8
        else $error("analog pin read as digital");
    a_p5_data_out: assert property (p5_fsel_r[6] |=> pd_r[4].o[6] == $past(p5_data_r[6])) // R9
        else $error("fifth port data not driven");
    a_p6_open_drain: assert property (1'b1 |=> pd_r[5].o == RST_ZERO && pd_r[5].oe == ~$past(p6_lvl)) // R10
        else $error("sixth port not open drain");
    a_disp_float: assert property (!disp_act_r |=> disp_drv.oe == RST_ZERO) // R11
        else $error("display driven before polarity write");
    a_rst_pin_drive: assert property (por_active |=> rst_pin_oe == POR_OPTION && !rst_pin_o) // R12
        else $error("reset pin not driven low");
    a_read_mix: assert property (s_rd_p1 |=> prdata[7:0] == $past(rd_word[0]) ##0 pready) // R14
        else $error("port read data wrong");

endmodule : mio_port_set

//--- test/mio_board_model.sv
// Board model: resolves pin levels from device drives and board sources.
// Assumes pull-ups on the open-drain sixth port and on the reset pin.
`timescale 1ns/1ps
module mio_board_model (
    input  wire mio_pkg::mio_pin_drv_t d1,
    input  wire mio_pkg::mio_pin_drv_t d2,
    input  wire mio_pkg::mio_pin_drv_t d3,
    input  wire mio_pkg::mio_pin_drv_t d4,
    input  wire mio_pkg::mio_pin_drv_t d6,
    input  wire logic [31:0]           ext,
    input  wire logic [7:0]            ext6,
    input  wire logic                  rst_o,
    input  wire logic                  rst_oe,
    input  wire logic                  ext_rst,
    output logic      [31:0]           pins,
    output logic      [7:0]            pin6,
    output logic                       rst_pin,
    output logic                       test_mode_pin
);
    import mio_pkg::*;
    // =========================================================
    // Pin resolution
    logic [31:0] oe32;
    assign oe32 = {d4.oe, d3.oe, d2.oe, d1.oe};
    assign pins = ({d4.o, d3.o, d2.o, d1.o} & oe32) | (ext & ~oe32);
    assign pin6 = ext6 & ~d6.oe;
    // pulled up, device may pull low
    assign rst_pin = ext_rst & ~(rst_oe & ~rst_o);
    assign test_mode_pin = 1'b0;
endmodule : mio_board_model

//--- test/tb.sv
// Self-checking bench for the multiplexed I/O port set.
// Assumes the board model resolves every pin level but the fifth port and display pins.
`timescale 1ns/1ps
module tb;
    import mio_pkg::*;
    // =========================================================
    // Signals
    logic         pclk;
    logic         presetn = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0]   paddr = 8'h00, ext6 = 8'hff, pwm8 = 8'h00, pin6;
    logic [31:0]  pwdata = 32'h0, ext = 32'hffffffff, rd, prdata, pins;
    logic [5:0]   p5 = 6'h3f, disp = 6'h00;
    logic [3:0]   i2d = 4'hf, asel, i2i;
    logic         sck_o = 1'b0, sck_oe = 1'b0, so_o = 1'b0, so_oe = 1'b0, wpwm = 1'b0, tsq = 1'b0;
    logic         por = 1'b0, erst = 1'b1, pready, pslverr, rpin, rpo, rpoe, srn, tmode, vs, hs, ia, ib, ic;
    wire  [5:0]   alt;
    mio_pin_drv_t d1, d2, d3, d4, d5, d6, dd;
    int           fail_count = 0, cmp_count = 0;

    mio_port_set dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_first_in(pins[7:0]), .port_second_in(pins[15:8]), .port_third_in(pins[23:16]),
        .port_fourth_in(pins[31:24]), .port_fifth_in(p5), .port_sixth_in(pin6),
        .port_first_drv(d1), .port_second_drv(d2), .port_third_drv(d3), .port_fourth_drv(d4),
        .port_fifth_drv(d5), .port_sixth_drv(d6), .screen_overlay_vsync(vs), .screen_overlay_hsync(hs),
        .ext_irq_a(ia), .ext_irq_b(ib), .ext_irq_c(ic), .ser_sck_o(sck_o), .ser_sck_oe(sck_oe),
        .ser_so_o(so_o), .ser_so_oe(so_oe), .ser_sck_in(alt[5]), .ser_si_in(alt[4]),
        .line_count_in_a(alt[3]), .line_count_in_b(alt[2]), .remote_rx_in(alt[1]), .event_count_in(alt[0]),
        .analog_in_sel(asel), .wide_pwm_in(wpwm), .timer_square_out(tsq), .narrow_pwm_in(pwm8),
        .i2c_line_drv(i2d), .i2c_line_in(i2i), .disp_in(disp), .disp_drv(dd), .rst_pin_in(rpin),
        .por_active(por), .rst_pin_o(rpo), .rst_pin_oe(rpoe), .sys_reset_n(srn)
    );
    mio_board_model board (
        .d1(d1), .d2(d2), .d3(d3), .d4(d4), .d6(d6), .ext(ext), .ext6(ext6), .rst_o(rpo),
        .rst_oe(rpoe), .ext_rst(erst), .pins(pins), .pin6(pin6), .rst_pin(rpin), .test_mode_pin(tmode)
    );

    // =========================================================
    // Common tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 8'h00);
        chk(rd, exp, what);
    endtask : rdc
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // =========================================================
    // Scenarios
    task automatic t_reset();
        rdc(A_P1_DIR, 32'h0, "p1 dir");
        rdc(A_P3_DIR, 32'h0, "p3 dir");
        rdc(A_P4_DIR, 32'h0, "p4 dir");
        chk({d1.oe, d2.oe, d3.oe, d4.oe}, 32'h0, "oe at reset");
        chk(d5, {RST_P5_DATA, P5_OE}, "p5 drive");
        chk({d6.oe, dd.oe}, 16'h0, "float");
        rdc(A_P5_FSEL, {24'h0, RST_P5_FSEL}, "fsel");
        chk({asel, vs, hs}, 6'h03, "analog, sync");
        apb(1'b0, 8'h3c, 8'h00);
        chk(rd, 32'h0, "unmapped data");
        chk(er, 1'b1, "unmapped error");
        $display("test reset done");
    endtask : t_reset
    task automatic t_ports();
        logic [7:0]   da [4] = '{A_P1_DATA, A_P2_DATA, A_P3_DATA, A_P4_DATA};
        mio_pin_drv_t dv;
        ext <= {4{8'hf0}};
        for (int i = 0; i < 4; i++) begin
            wr(da[i] + 8'h04, 8'h5a);
            wr(da[i], 8'h3c);
            cyc(8);
            dv = (i == 0) ? d1 : (i == 1) ? d2 : (i == 2) ? d3 : d4;
            chk({dv.oe, dv.o & dv.oe}, 16'h5a18, "dir and data");
            rdc(da[i], 32'hb8, "mixed read");
            wr(da[i] + 8'h04, 8'h00);
        end
        ext <= '1;
        cyc(8);
        $display("test ports done");
    endtask : t_ports
    task automatic t_irq();
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            if (k == 2) ext[24] <= 1'b0;
            else p5[k] <= 1'b0;
            repeat (12) begin
                @(posedge pclk);
                n += (k == 0) ? ia : (k == 1) ? ib : ic;
            end
            p5 <= 6'h3f;
            ext <= '1;
            repeat (12) begin
                @(posedge pclk);
                n += (k == 0) ? ia : (k == 1) ? ib : ic;
            end
            chk(n, 1, "irq pulses");
        end
        $display("test irq done");
    endtask : t_irq
    task automatic t_sync();
        ext[7:0] <= 8'hbf;
        cyc(8);
        chk({vs, hs}, 2'b11, "sync gated");
        wr(A_MISC, 8'h01);
        cyc(8);
        chk({vs, hs}, 2'b01, "sync pass");
        wr(A_MISC, 8'h00);
        ext <= '1;
        $display("test sync done");
    endtask : t_sync
    task automatic t_serial();
        wr(A_MISC, 8'h06);
        sck_o <= 1'b1;
        sck_oe <= 1'b1;
        so_oe <= 1'b1;
        cyc(3);
        chk({d4.o[2:1], d4.oe[2:1]}, 4'b0111, "serial drive");
        sck_oe <= 1'b0;
        ext[31:24] <= 8'h6b;
        cyc(8);
        chk(alt, 6'h36, "alt inputs");
        rdc(A_P4_DATA, 32'h6b, "p4 read");
        ext[31:24] <= 8'h95;
        cyc(8);
        chk(alt, 6'h09, "alt inputs");
        rdc(A_P4_DATA, 32'h91, "p4 read");
        wr(A_MISC, 8'h00);
        ext <= '1;
        $display("test serial done");
    endtask : t_serial
    task automatic t_fifth();
        wr(A_P5_FSEL, 8'hfc);
        cyc(3);
        chk(asel, 4'hf, "analog sel");
        rdc(A_P5_DATA, 32'hc3, "analog read");
        wr(A_P5_FSEL, 8'h00);
        wpwm <= 1'b1;
        cyc(3);
        chk(d5.o[7:6], 2'b01, "alt out");
        {tsq, wpwm} <= 2'b10;
        cyc(3);
        chk(d5.o[7:6], 2'b10, "alt out");
        wr(A_P5_FSEL, 8'hc0);
        cyc(3);
        rdc(A_P5_DATA, 32'hff, "p5 read");
        chk(d5.oe, P5_OE, "fixed dir");
        $display("test fifth done");
    endtask : t_fifth
    task automatic t_sixth();
        wr(A_P6_DATA, 8'h5a);
        cyc(3);
        chk(d6.oe, 8'ha5, "od data");
        pwm8 <= 8'h33;
        wr(A_P6_PWM, 8'hff);
        cyc(3);
        chk(d6.oe, 8'hcc, "od pwm");
        i2d <= 4'b0110;
        wr(A_P6_I2C, 8'h0f);
        cyc(8);
        chk({d6.oe, i2i}, 12'h9c6, "od i2c");
        ext6 <= 8'hdf;
        cyc(8);
        chk(i2i, 4'h4, "peer low");
        ext6 <= 8'hff;
        $display("test sixth done");
    endtask : t_sixth
    task automatic t_disp_rst();
        disp <= 6'h15;
        cyc(3);
        chk(dd.oe, 8'h00, "disp float");
        wr(A_POL, 8'h0f);
        cyc(3);
        chk(dd, 16'h1a3f, "disp active");
        por <= 1'b1;
        cyc(10);
        chk({rpoe, rpo, srn}, 3'b100, "por drive");
        por <= 1'b0;
        cyc(10);
        chk({rpoe, srn}, 2'b01, "por release");
        $display("test display and reset pin done");
    endtask : t_disp_rst

    // =========================================================
    // Clock, watchdog, sequence
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #(40 * 20000);
        fail_count++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        cyc(10);
        presetn <= 1'b1;
        cyc(8);
        t_reset();
        t_ports();
        t_irq();
        t_sync();
        t_serial();
        t_fifth();
        t_sixth();
        t_disp_rst();
        end_of_test();
    end
endmodule : tb
